// *** verilog/utsf_pkg.sv ***
// Purpose: Shared constants, carriers and decoders for the transmit status flag block
// Assumes: Avalon-MM slave, 32-bit data, byte addresses, one 40 MHz clock
// Notes:   Register offsets are word aligned; unused bits read as zero
package utsf_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int DATA_W     = 8;
    localparam int FIFO_DEPTH = 64;
    localparam int CNT_W      = 7;
    localparam int PTR_W      = 6;
    localparam int ADDR_W     = 8;
    localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 7'h40;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_TX_DATA  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_FIFO_CTL = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_FIFO_CNT = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int ST_END_BIT    = 6;
    localparam int ST_EMPTY_BIT  = 5;
    localparam int CTL_THR_HI    = 5;
    localparam int CTL_THR_LO    = 4;
    localparam int IRQ_END_BIT   = 0;
    localparam int IRQ_EMPTY_BIT = 1;
    localparam int IRQ_W         = 2;
    localparam logic [1:0]       THR_CODE_RST = 2'h0;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;
    localparam logic             END_FLAG_RST   = 1'b1;
    localparam logic             EMPTY_FLAG_RST = 1'b1;

    // Trigger numbers per threshold code
    localparam logic [CNT_W-1:0] TRIG_CODE0 = 7'h20;
    localparam logic [CNT_W-1:0] TRIG_CODE1 = 7'h10;
    localparam logic [CNT_W-1:0] TRIG_CODE2 = 7'h02;
    localparam logic [CNT_W-1:0] TRIG_CODE3 = 7'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ     = 40_000_000;
    localparam int BAUD_BPS   = 115_200;
    localparam int BIT_CYCLES = CLK_HZ / BAUD_BPS;
    localparam int DIV_W      = 9;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BIT_CYCLES - 1);
    localparam logic [2:0]       BIT_LAST = 3'h7;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [31:0]       writedata;
    } utsf_avs_req_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } utsf_avs_rsp_s;

    typedef enum logic [1:0] {
        SH_IDLE  = 2'h0,
        SH_START = 2'h1,
        SH_DATA  = 2'h3,
        SH_STOP  = 2'h2
    } utsf_shift_e;

    // ------------------------------------------------------------------
    // Decoders
    // ------------------------------------------------------------------
    function automatic logic utsf_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
        return addr == ofs;
    endfunction

    function automatic logic [CNT_W-1:0] utsf_trig(input logic [1:0] code);
        logic [CNT_W-1:0] t;
        unique case (code)
            2'h0: t = TRIG_CODE0;
            2'h1: t = TRIG_CODE1;
            2'h2: t = TRIG_CODE2;
            2'h3: t = TRIG_CODE3;
        endcase
        return t;
    endfunction

endpackage

// *** verilog/utsf_fifo.sv ***
// Purpose: 64-byte transmit store in flip-flops
// Assumes: Caller only pushes when not full and pops when not empty
// Notes:   Count is the live fill level
`timescale 1ns/10ps
module utsf_fifo
    import utsf_pkg::*;
(
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    // Fill side
    input  wire logic              push,
    input  wire logic [DATA_W-1:0] push_data,
    // Drain side
    input  wire logic              pop,
    output logic      [DATA_W-1:0] pop_data,
    // Level
    output logic      [CNT_W-1:0]  count
);

    // (R7) 64-entry store
    logic [DATA_W-1:0] mem [FIFO_DEPTH];
    logic [PTR_W-1:0]  wr_ptr;
    logic [PTR_W-1:0]  rd_ptr;
    logic [CNT_W-1:0]  next_count;

    assign next_count = CNT_W'(count + CNT_W'(push) - CNT_W'(pop));
    assign pop_data   = mem[rd_ptr];

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= push_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= PTR_W'(wr_ptr + PTR_W'(push));
            rd_ptr <= PTR_W'(rd_ptr + PTR_W'(pop));
            count  <= next_count;
        end
    end

    property p_fifo_no_overfill;
        @(posedge ref_clk) disable iff (!rst_b)
        count == FIFO_FULL_CNT && !pop |=> count == FIFO_FULL_CNT;
    endproperty
    a_fifo_no_overfill: assert property (p_fifo_no_overfill) else $error("fill level moved past full"); // (R7)

endmodule

// *** verilog/utsf_shifter.sv ***
// Purpose: 8N1 serial shifter fed from the transmit store
// Assumes: Bit rate from a divider enable pulse
// Notes:   Load pulse moves one byte out of the store
`timescale 1ns/10ps
module utsf_shifter
    import utsf_pkg::*;
(
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    // Store side
    input  wire logic              avail,
    input  wire logic [DATA_W-1:0] data,
    output logic                   load,
    // Status
    output logic                   busy,
    output logic                   done,
    // Line
    output logic                   txd
);

    utsf_shift_e       state;
    logic [DATA_W-1:0] shreg;
    logic [DIV_W-1:0]  div;
    logic [2:0]        bit_idx;
    logic              bit_en;

    // ------------------------------------------------------------------
    // Bit rate divider
    // ------------------------------------------------------------------
    assign bit_en = (state != SH_IDLE) && (div == DIV_LAST);
    assign load   = (state == SH_IDLE) && avail;
    assign busy   = state != SH_IDLE;
    assign done   = (state == SH_STOP) && bit_en;

    always_ff @(posedge ref_clk) begin
        if (!rst_b || load || bit_en) begin
            div <= '0;
        end else if (busy) begin
            div <= DIV_W'(div + 1'b1);
        end
    end

    // ------------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state   <= SH_IDLE;
            shreg   <= '0;
            bit_idx <= '0;
            txd     <= 1'b1;
        end else begin
            unique case (state)
                SH_IDLE: begin
                    if (avail) begin
                        shreg <= data;
                        txd   <= 1'b0;
                        state <= SH_START;
                    end
                end
                SH_START: begin
                    if (bit_en) begin
                        txd     <= shreg[0];
                        shreg   <= shreg >> 1;
                        bit_idx <= '0;
                        state   <= SH_DATA;
                    end
                end
                SH_DATA: begin
                    if (bit_en) begin
                        if (bit_idx == BIT_LAST) begin
                            txd   <= 1'b1;
                            state <= SH_STOP;
                        end else begin
                            txd     <= shreg[0];
                            shreg   <= shreg >> 1;
                            bit_idx <= 3'(bit_idx + 1'b1);
                        end
                    end
                end
                SH_STOP: begin
                    if (bit_en) begin
                        state <= SH_IDLE;
                    end
                end
            endcase
        end
    end

endmodule

// *** verilog/utsf_top.sv ***
// Purpose: Transmit end and transmit store empty flags with store, shifter and register slave
// Assumes: Avalon-MM master honours waitrequest; one clock ref_clk
// Notes:   Every top output comes from a flip-flop
//
// Behaviour
// (R1) End flag reads 0 while sending, 1 when done; read-only, resets to 1.
// (R2) End flag sets when last stop bit leaves and the store is empty.
// (R3) End flag clears whenever new data is written to the store.
// (R4) Empty flag sets when a load leaves fill at or below the trigger.
// (R5) Empty flag is forced to 1 by reset.
// (R6) Empty flag clears only when fill exceeds trigger and 0 follows a read of 1.
// (R7) Store holds 64 bytes; software may write 64 minus trigger when flag set.
// (R8) Bytes written beyond free space are dropped.
// (R9) Current fill level readable in the count register.
// (R10) Trigger comes from the two threshold bits of the control register.
// (R11) Writing 1 leaves empty flag; a 0 without prior read of 1 does nothing.
//
// The implementer's own choices: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
module utsf_top
    import utsf_pkg::*;
(
    // Clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst_b,
    // Register bus
    input  wire utsf_avs_req_s avs_req,
    output utsf_avs_rsp_s      avs_rsp,
    // Serial line
    output logic               txd,
    // Interrupt
    output logic               irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic             wait_q;
    logic [31:0]      rdata_q;
    logic             tx_end_flag;
    logic             tx_fifo_empty_flag;
    logic             empty_armed;
    logic             tx_threshold_hi_bit;
    logic             tx_threshold_lo_bit;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic             rd_acc;
    logic             wr_acc;
    logic             wr_data;
    logic             wr_status;
    logic             rd_status;
    logic             wr_ctl;
    logic             wr_irq_stat;
    logic             wr_irq_mask;
    logic [31:0]      rd_word;
    logic [31:0]      status_word;

    assign rd_acc      = avs_req.read && !wait_q;
    assign wr_acc      = avs_req.write && !wait_q;
    assign wr_data     = wr_acc && utsf_hit(avs_req.address, OFS_TX_DATA);
    assign wr_status   = wr_acc && utsf_hit(avs_req.address, OFS_STATUS);
    assign rd_status   = rd_acc && utsf_hit(avs_req.address, OFS_STATUS);
    assign wr_ctl      = wr_acc && utsf_hit(avs_req.address, OFS_FIFO_CTL);
    assign wr_irq_stat = wr_acc && utsf_hit(avs_req.address, OFS_IRQ_STAT);
    assign wr_irq_mask = wr_acc && utsf_hit(avs_req.address, OFS_IRQ_MASK);

    // ------------------------------------------------------------------
    // Store and shifter
    // ------------------------------------------------------------------
    logic [CNT_W-1:0]  count;
    logic [DATA_W-1:0] pop_data;
    logic              push;
    logic              pop;
    logic              shift_busy;
    logic              shift_done;
    logic              fifo_empty;
    logic [CNT_W-1:0]  next_count;
    logic [CNT_W-1:0]  thr;

    // (R8) drop when full
    assign push       = wr_data && (count != FIFO_FULL_CNT);
    assign fifo_empty = count == '0;
    assign next_count = CNT_W'(count + CNT_W'(push) - CNT_W'(pop));
    // (R10) trigger from threshold bits
    assign thr        = utsf_trig({tx_threshold_hi_bit, tx_threshold_lo_bit});

    utsf_fifo u_fifo (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .push      (push),
        .push_data (avs_req.writedata[DATA_W-1:0]),
        .pop       (pop),
        .pop_data  (pop_data),
        .count     (count)
    );

    utsf_shifter u_shifter (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .avail   (!fifo_empty),
        .data    (pop_data),
        .load    (pop),
        .busy    (shift_busy),
        .done    (shift_done),
        .txd     (txd)
    );

    // ------------------------------------------------------------------
    // Flag logic
    // ------------------------------------------------------------------
    logic end_set;
    logic empty_set;
    logic empty_clr;
    logic next_end;
    logic next_empty;
    logic next_armed;

    // (R2) last bit out, nothing left
    assign end_set    = shift_done && fifo_empty && !push;
    // (R3) written data wins
    assign next_end   = !wr_data && (end_set || tx_end_flag);
    // (R4) load drops to trigger
    assign empty_set  = pop && (next_count <= thr);
    // (R6) armed, above trigger, zero written
    assign empty_clr  = wr_status && !avs_req.writedata[ST_EMPTY_BIT] && empty_armed && (count > thr);
    // (R11) set beats clear, ones ignored
    assign next_empty = empty_set || (tx_fifo_empty_flag && !empty_clr);
    // (R11) arm only on a read that returned 1
    assign next_armed = tx_fifo_empty_flag && !empty_clr && ((rd_status && rdata_q[ST_EMPTY_BIT]) || empty_armed);

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            // (R1) (R5) both flags start high
            tx_end_flag        <= END_FLAG_RST;
            tx_fifo_empty_flag <= EMPTY_FLAG_RST;
            empty_armed        <= 1'b0;
        end else begin
            tx_end_flag        <= next_end;
            tx_fifo_empty_flag <= next_empty;
            empty_armed        <= next_armed;
        end
    end

    // ------------------------------------------------------------------
    // Control and interrupt registers
    // ------------------------------------------------------------------
    logic [IRQ_W-1:0] irq_ev;
    logic [IRQ_W-1:0] next_irq_stat;
    logic [IRQ_W-1:0] next_irq_mask;

    assign irq_ev[IRQ_END_BIT]   = end_set && !tx_end_flag;
    assign irq_ev[IRQ_EMPTY_BIT] = empty_set && !tx_fifo_empty_flag;
    assign next_irq_stat = irq_ev | (irq_stat & ~({IRQ_W{wr_irq_stat}} & avs_req.writedata[IRQ_W-1:0]));
    assign next_irq_mask = wr_irq_mask ? avs_req.writedata[IRQ_W-1:0] : irq_mask;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tx_threshold_hi_bit <= THR_CODE_RST[1];
            tx_threshold_lo_bit <= THR_CODE_RST[0];
            irq_stat            <= '0;
            irq_mask            <= IRQ_MASK_RST;
            irq                 <= 1'b0;
        end else begin
            if (wr_ctl) begin
                tx_threshold_hi_bit <= avs_req.writedata[CTL_THR_HI];
                tx_threshold_lo_bit <= avs_req.writedata[CTL_THR_LO];
            end
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            irq      <= |(next_irq_stat & next_irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // Read mux and handshake
    // ------------------------------------------------------------------
    assign status_word = (32'(tx_end_flag) << ST_END_BIT) | (32'(tx_fifo_empty_flag) << ST_EMPTY_BIT);

    // (R9) fill level register
    assign rd_word =
        utsf_hit(avs_req.address, OFS_STATUS)   ? status_word :
        utsf_hit(avs_req.address, OFS_FIFO_CTL) ?
            ((32'(tx_threshold_hi_bit) << CTL_THR_HI) | (32'(tx_threshold_lo_bit) << CTL_THR_LO)) :
        utsf_hit(avs_req.address, OFS_FIFO_CNT) ? 32'(count) :
        utsf_hit(avs_req.address, OFS_IRQ_STAT) ? 32'(irq_stat) :
        utsf_hit(avs_req.address, OFS_IRQ_MASK) ? 32'(irq_mask) :
        32'h0;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0;
        end else begin
            wait_q <= !((avs_req.read || avs_req.write) && wait_q);
            if (avs_req.read && wait_q) begin
                rdata_q <= rd_word;
            end
        end
    end

    assign avs_rsp = '{readdata: rdata_q, waitrequest: wait_q};

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_flags_after_reset;
        @(posedge ref_clk)
        !rst_b |=> tx_end_flag && tx_fifo_empty_flag && !irq;
    endproperty
    a_flags_after_reset: assert property (p_flags_after_reset) else $error("flags not high after reset"); // (R5)

    property p_end_low_while_busy;
        @(posedge ref_clk) disable iff (!rst_b)
        shift_busy && !$past(end_set) |-> !tx_end_flag;
    endproperty
    a_end_low_while_busy: assert property (p_end_low_while_busy) else $error("end flag high mid frame"); // (R1)

    property p_end_set;
        @(posedge ref_clk) disable iff (!rst_b)
        shift_done && fifo_empty && !wr_data |=> tx_end_flag ##1 (tx_end_flag || $past(wr_data));
    endproperty
    a_end_set: assert property (p_end_set) else $error("end flag missed final bit"); // (R2)

    property p_end_clear;
        @(posedge ref_clk) disable iff (!rst_b)
        wr_data |=> !tx_end_flag;
    endproperty
    a_end_clear: assert property (p_end_clear) else $error("end flag survived a data write"); // (R3)

    property p_empty_set;
        @(posedge ref_clk) disable iff (!rst_b)
        pop && (CNT_W'(count - 1'b1 + CNT_W'(push)) <= thr) |=> tx_fifo_empty_flag;
    endproperty
    a_empty_set: assert property (p_empty_set) else $error("empty flag missed low fill"); // (R4)

    property p_empty_clear_cause;
        @(posedge ref_clk) disable iff (!rst_b)
        $fell(tx_fifo_empty_flag) |-> $past(empty_armed) && ($past(count) > $past(thr)) && $past(wr_status);
    endproperty
    a_empty_clear_cause: assert property (p_empty_clear_cause) else $error("empty flag cleared without cause"); // (R6)

    property p_empty_one_write;
        @(posedge ref_clk) disable iff (!rst_b)
        tx_fifo_empty_flag && wr_status && avs_req.writedata[ST_EMPTY_BIT] |=> tx_fifo_empty_flag;
    endproperty
    a_empty_one_write: assert property (p_empty_one_write) else $error("writing one cleared empty flag"); // (R11)

    property p_drop_when_full;
        @(posedge ref_clk) disable iff (!rst_b)
        wr_data && count == FIFO_FULL_CNT |-> !push;
    endproperty
    a_drop_when_full: assert property (p_drop_when_full) else $error("byte stored into full store"); // (R8)

    property p_count_read;
        @(posedge ref_clk) disable iff (!rst_b)
        rd_acc && utsf_hit(avs_req.address, OFS_FIFO_CNT) |-> rdata_q == 32'($past(count));
    endproperty
    a_count_read: assert property (p_count_read) else $error("count register wrong"); // (R9)

    property p_one_wait_cycle;
        @(posedge ref_clk) disable iff (!rst_b)
        (avs_req.read || avs_req.write) && wait_q |=> !wait_q ##1 wait_q;
    endproperty
    a_one_wait_cycle: assert property (p_one_wait_cycle) else $error("waitrequest timing off");

    property p_wait_idle;
        @(posedge ref_clk) disable iff (!rst_b)
        !avs_req.read && !avs_req.write |=> wait_q;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low with no request");

    property p_arm_on_read_one;
        @(posedge ref_clk) disable iff (!rst_b)
        !empty_armed && !(rd_status && rdata_q[ST_EMPTY_BIT]) |=> !empty_armed;
    endproperty
    a_arm_on_read_one: assert property (p_arm_on_read_one) else $error("clear armed without a read of one"); // (R11)

    property p_empty_only_on_load;
        @(posedge ref_clk) disable iff (!rst_b)
        !tx_fifo_empty_flag && !pop |=> !tx_fifo_empty_flag;
    endproperty
    a_empty_only_on_load: assert property (p_empty_only_on_load) else $error("empty flag set without a load"); // (R4)

    property p_end_only_on_done;
        @(posedge ref_clk) disable iff (!rst_b)
        !tx_end_flag && !shift_done |=> !tx_end_flag;
    endproperty
    a_end_only_on_done: assert property (p_end_only_on_done) else $error("end flag set without a final bit"); // (R2)

    property p_count_hold;
        @(posedge ref_clk) disable iff (!rst_b)
        !push && !pop |=> count == $past(count);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("fill level moved with no push or pop"); // (R8)

    property p_irq_level;
        @(posedge ref_clk) disable iff (!rst_b)
        irq == |(irq_stat & irq_mask);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq differs from unmasked status");

endmodule

// *** test/utsf_line_rx.sv ***
// Purpose: Remote serial receiver on the transmit line
// Assumes: 8N1, LSB first, BIT_CYCLES clocks per bit
// Notes:   Frames with a bad start or stop bit are counted, not stored
`timescale 1ns/10ps
module utsf_line_rx
    import utsf_pkg::*;
(
    // Clock and line
    input wire logic ref_clk,
    input wire logic txd
);
    logic [9:0]        frame;
    logic [DATA_W-1:0] got[$];
    int                n_bad = 0;

    // Sample each bit at its middle
    initial forever begin
        @(negedge txd);
        repeat (BIT_CYCLES / 2) @(posedge ref_clk);
        for (int i = 0; i < 10; i++) begin
            frame = {txd, frame[9:1]};
            if (i < 9) begin
                repeat (BIT_CYCLES) @(posedge ref_clk);
            end
        end
        if (frame[0] === 1'b0 && frame[9] === 1'b1) begin
            got.push_back(frame[8:1]);
        end else begin
            n_bad++;
        end
    end
endmodule

// *** test/utsf_top_tb.sv ***
// Purpose: Self-checking bench for the transmit status flags
// Assumes: Register map and trigger codes of utsf_pkg
// Notes:   A full store is left by reset; draining it would take too long
`timescale 1ns/10ps
module utsf_top_tb
    import utsf_pkg::*;
();
    localparam logic [31:0] END_M = 32'h1 << ST_END_BIT;
    localparam logic [31:0] EMP_M = 32'h1 << ST_EMPTY_BIT;

    logic              ref_clk = 1'b0;
    logic              rst_b = 1'b0;
    utsf_avs_req_s     req = '0;
    utsf_avs_rsp_s     rsp;
    logic              txd;
    logic              irq;
    logic [31:0]       q;
    logic [DATA_W-1:0] sent[4] = '{8'ha5, 8'h3c, 8'h81, 8'h0f};
    int                n_mismatch = 0;
    int                checks_done = 0;

    utsf_top u_utsf_top (.ref_clk(ref_clk), .rst_b(rst_b), .avs_req(req), .avs_rsp(rsp), .txd(txd), .irq(irq));
    utsf_line_rx u_utsf_line_rx (.ref_clk(ref_clk), .txd(txd));

    initial forever #12.5 ref_clk = ~ref_clk;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic give_verdict();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req.write <= wr;
        req.read <= !wr;
        req.address <= a;
        req.writedata <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 50);
        if (rsp.waitrequest !== 1'b0) begin
            n_mismatch++;
            give_verdict();
        end
        q = rsp.readdata;
        req.write <= 1'b0;
        req.read <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, exp, q);
    endtask

    task automatic poll(input int b);
        int n;
        n = 0;
        do begin
            bus(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (q[b] !== 1'b1 && n < 9000);
        if (q[b] !== 1'b1) begin
            n_mismatch++;
            give_verdict();
        end
    endtask

    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_vals();
        rd("status", OFS_STATUS, END_M | EMP_M);
        rd("count", OFS_FIFO_CNT, 32'h0);
        rd("unmapped", 8'h20, 32'h0);
        rd("irq_stat", OFS_IRQ_STAT, 32'h0);
    endtask

    task automatic t_send_clear();
        wr(OFS_FIFO_CTL, 32'h1 << CTL_THR_HI);
        rd("ctl", OFS_FIFO_CTL, 32'h1 << CTL_THR_HI);
        wr(OFS_IRQ_MASK, 32'h3);
        foreach (sent[i]) wr(OFS_TX_DATA, {24'h0, sent[i]});
        rd("count", OFS_FIFO_CNT, 32'(TRIG_CODE2) + 32'h1);
        rd("status", OFS_STATUS, EMP_M);
        wr(OFS_STATUS, 32'h0);
        rd("status", OFS_STATUS, 32'h0);
        poll(ST_EMPTY_BIT);
        rd("count", OFS_FIFO_CNT, 32'(TRIG_CODE2));
        chk("irq", 32'h1, {31'h0, irq});
        rd("irq_stat", OFS_IRQ_STAT, 32'h2);
        wr(OFS_IRQ_STAT, 32'h2);
        chk("irq", 32'h0, {31'h0, irq});
        rd("irq_stat", OFS_IRQ_STAT, 32'h0);
    endtask

    task automatic t_end();
        poll(ST_END_BIT);
        rd("count", OFS_FIFO_CNT, 32'h0);
        rd("irq_stat", OFS_IRQ_STAT, 32'h1);
        chk("irq", 32'h1, {31'h0, irq});
        wr(OFS_IRQ_MASK, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        wr(OFS_STATUS, 32'h0);
        rd("status", OFS_STATUS, END_M | EMP_M);
        chk("rx_n", 32'd4, u_utsf_line_rx.got.size());
        chk("rx_bad", 32'd0, u_utsf_line_rx.n_bad);
        foreach (sent[i]) chk("rx_byte", {24'h0, sent[i]}, {24'h0, u_utsf_line_rx.got[i]});
    endtask

    task automatic t_overfill();
        do_reset();
        wr(OFS_FIFO_CTL, 32'h1 << CTL_THR_LO);
        rd("ctl", OFS_FIFO_CTL, 32'h1 << CTL_THR_LO);
        // First byte moves to the shifter, leaving fill at the trigger
        repeat (int'(TRIG_CODE1) + 1) wr(OFS_TX_DATA, 32'h55);
        rd("count", OFS_FIFO_CNT, 32'(TRIG_CODE1));
        wr(OFS_STATUS, 32'h0);
        rd("status", OFS_STATUS, EMP_M);
        wr(OFS_STATUS, 32'h0);
        rd("status", OFS_STATUS, EMP_M);
        repeat (FIFO_DEPTH - int'(TRIG_CODE1) + 1) wr(OFS_TX_DATA, 32'h55);
        rd("count", OFS_FIFO_CNT, 32'(FIFO_DEPTH));
        wr(OFS_STATUS, EMP_M);
        rd("status", OFS_STATUS, EMP_M);
        wr(OFS_STATUS, 32'h0);
        rd("status", OFS_STATUS, 32'h0);
        do_reset();
        rd("status", OFS_STATUS, END_M | EMP_M);
        rd("count", OFS_FIFO_CNT, 32'h0);
        wr(OFS_FIFO_CTL, 32'h3 << CTL_THR_LO);
        rd("ctl", OFS_FIFO_CTL, 32'h3 << CTL_THR_LO);
    endtask

    initial begin
        repeat (100000) @(posedge ref_clk);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        @(posedge ref_clk);
        do_reset();
        t_reset_vals();
        t_send_clear();
        t_end();
        t_overfill();
        give_verdict();
    end
endmodule
